// ### inc/tmc_regs.vh
`ifndef TMC_REGS_VH
`define TMC_REGS_VH

// register byte addresses
`define TMC_ADDR_CTRL      8'h00
`define TMC_ADDR_LOW       8'h04
`define TMC_ADDR_HIGH      8'h08
`define TMC_ADDR_STATUS    8'h0c
`define TMC_ADDR_PINS      8'h10

// control register fields
`define TMC_CTL_ON         0
`define TMC_CTL_SRC        1
`define TMC_CTL_SYNCDIS    2
`define TMC_CTL_OSCEN      3
`define TMC_CTL_PS_LO      4
`define TMC_CTL_PS_HI      5
`define TMC_CTL_GATEEN     6
`define TMC_CTL_GATEINV    7
`define TMC_CTL_ALT        8
`define TMC_CTL_W          9
`define TMC_CTL_RESET      9'h000

// status register fields
`define TMC_STA_OVF        0
`define TMC_STA_WAKE       1

// pin register fields
`define TMC_PIN_DIR4       0
`define TMC_PIN_DIR5       1
`define TMC_PIN_OUT4       2
`define TMC_PIN_OUT5       3
`define TMC_PIN_IN4        4
`define TMC_PIN_IN5        5
`define TMC_PIN_W          4
`define TMC_PIN_RESET      4'h3

// prescale-select encodings
`define TMC_PS_DIV1        2'h0
`define TMC_PS_DIV2        2'h1
`define TMC_PS_DIV4        2'h2
`define TMC_PS_DIV8        2'h3

// instruction clock is the system clock divided by four
`define TMC_PHASE_LAST     2'h3
`define TMC_COUNT_RESET    16'h0000
`define TMC_COUNT_ALL_ONES 16'hffff

`endif

// ### rtl/tmc_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "tmc_regs.vh"

// Overview of operation
// RULE_01: sixteen-bit up-counter read as two bytes
// RULE_02: count byte write replaces that byte immediately
// RULE_03: source picks instruction clock, system clock, pin
// RULE_04: internal source advances per prescaled instruction cycle
// RULE_05: external source counts prescaled rising pin edges
// RULE_06: sync_disable selects asynchronous external counting; here it only permits counting in sleep, pin still synchronised
// RULE_07: counter mode needs falling edge before rising
// RULE_08: prescaler divides by one, two, four, eight
// RULE_09: prescaler hidden, cleared by count byte writes
// RULE_10: osc_enable starts crystal oscillator, runs in sleep
// RULE_11: oscillator usable only with internal or low-power clock
// RULE_12: oscillator forces pin directions input, data zero
// RULE_13: software waits oscillator start-up before timer_on
// RULE_14: asynchronous mode counts in sleep, overflow wakes
// RULE_15: software takes care reading asynchronous counter bytes
// RULE_16: mode switch may lose or add one count
// RULE_17: rollover sets overflow flag until software clears
// RULE_18: prescale codes 11/10/01/00 give 8/4/2/1
// RULE_19: timer_on clear stops counting, holds value
// RULE_20: gate_enable counts only while gate is active
// RULE_21: external pin two-flop synchronised, edge one pulse
module tmc_timer (
   input  wire        clk,          // system clock, 10 MHz
   input  wire        rst,          // synchronous reset, active high
   input  wire        psel,         // apb select
   input  wire        penable,      // apb access phase
   input  wire        pwrite,       // apb direction, high for write
   input  wire [7:0]  paddr,        // apb byte address
   input  wire [31:0] pwdata,       // apb write data
   output reg  [31:0] prdata,       // apb read data
   output reg         pready,       // apb ready
   output reg         pslverr,      // apb error on unmapped address
   input  wire        ext_count_pin,// external count input pin
   input  wire        gate_pin,     // gate signal
   input  wire        pin4_in,      // pin 4 input level
   input  wire        pin5_in,      // pin 5 input level
   output reg         pin4_out,     // pin 4 output level
   output reg         pin4_oe,      // pin 4 drive enable
   output reg         pin5_out,     // pin 5 output level
   output reg         pin5_oe,      // pin 5 drive enable
   input  wire        osc_allowed,  // system clock mode allows the crystal
   input  wire        sleep,        // core asleep
   output reg         osc_run,      // crystal oscillator enable
   output reg         overflow_flag,// sticky rollover flag
   output reg         wake          // wake request on sleep overflow
);

   // apb phase decode
   wire        acc      = psel & penable & pready;
   wire        wr       = acc & pwrite;
   reg  [`TMC_CTL_W-1:0] ctrl;
   reg  [`TMC_PIN_W-1:0] pins;
   reg  [15:0] count;
   reg  [2:0]  pre;
   reg  [1:0]  phase;
   reg         ext_m;
   reg         ext_s;
   reg         ext_d;
   reg         gate_m;
   reg         gate_s;
   reg         p4_m;
   reg         p4_s;
   reg         p5_m;
   reg         p5_s;
   reg         armed;

   // true when the address names a mapped register
   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `TMC_ADDR_CTRL) || (a == `TMC_ADDR_LOW) ||
                  (a == `TMC_ADDR_HIGH) || (a == `TMC_ADDR_STATUS) ||
                  (a == `TMC_ADDR_PINS);
      end
   endfunction

   // prescaler terminal value for a select code
   function [2:0] pre_last;
      input [1:0] ps;
      begin
         case (ps)
            `TMC_PS_DIV1: pre_last = 3'h0; // RULE_18
            `TMC_PS_DIV2: pre_last = 3'h1; // RULE_18
            `TMC_PS_DIV4: pre_last = 3'h3; // RULE_18
            default:      pre_last = 3'h7; // RULE_18
         endcase
      end
   endfunction

   wire wr_low   = wr & (paddr == `TMC_ADDR_LOW);
   wire wr_high  = wr & (paddr == `TMC_ADDR_HIGH);
   wire wr_count = wr_low | wr_high;
   // register strobes, taken at the completing edge
   wire wr_ctrl  = wr & (paddr == `TMC_ADDR_CTRL);
   wire wr_pins  = wr & (paddr == `TMC_ADDR_PINS);
   wire wr_stat  = wr & (paddr == `TMC_ADDR_STATUS);
   wire rd_req   = psel & penable & ~pready & ~pwrite;
   wire on       = ctrl[`TMC_CTL_ON];
   wire src_ext  = ctrl[`TMC_CTL_SRC];
   wire async    = src_ext & ctrl[`TMC_CTL_SYNCDIS]; // RULE_06 RULE_16
   wire osc_on   = ctrl[`TMC_CTL_OSCEN] & osc_allowed; // RULE_11
   wire gate_act = gate_s ~^ ctrl[`TMC_CTL_GATEINV];
   wire rise     = ext_s & ~ext_d; // RULE_21
   wire fall     = ~ext_s & ext_d;

   // raw input tick for the selected source
   reg  raw_tick;
   always @* begin
      if (src_ext) begin
         raw_tick = rise & armed; // RULE_05 RULE_07
      end else if (ctrl[`TMC_CTL_ALT]) begin
         raw_tick = 1'b1; // RULE_03
      end else begin
         raw_tick = (phase == `TMC_PHASE_LAST); // RULE_03 RULE_04
      end
   end

   // counting permitted: on, gated, and awake unless asynchronous
   wire run      = on & (~ctrl[`TMC_CTL_GATEEN] | gate_act) &
                   (~sleep | async); // RULE_19 RULE_20 RULE_14
   wire pre_done = (pre == pre_last(ctrl[`TMC_CTL_PS_HI:`TMC_CTL_PS_LO]));
   wire inc      = run & raw_tick & pre_done & ~wr_count; // RULE_08
   wire roll     = inc & (count == `TMC_COUNT_ALL_ONES);

   // two-flop synchroniser and edge delay for the count pin
   always @(posedge clk) begin
      if (rst) begin
         ext_m  <= 1'b0;
         ext_s  <= 1'b0;
         ext_d  <= 1'b0;
      end else begin
         ext_m  <= ext_count_pin; // RULE_21 RULE_06
         ext_s  <= ext_m;
         ext_d  <= ext_s;
      end
   end

   // two-flop synchronisers for the gate and general pins
   always @(posedge clk) begin
      if (rst) begin
         gate_m <= 1'b0;
         gate_s <= 1'b0;
         p4_m   <= 1'b0;
         p4_s   <= 1'b0;
         p5_m   <= 1'b0;
         p5_s   <= 1'b0;
      end else begin
         gate_m <= gate_pin;
         gate_s <= gate_m;
         p4_m   <= pin4_in;
         p4_s   <= p4_m;
         p5_m   <= pin5_in;
         p5_s   <= p5_m;
      end
   end

   // instruction phase and hidden prescaler
   always @(posedge clk) begin
      if (rst) begin
         phase <= 2'h0;
         pre   <= 3'h0;
      end else begin
         phase <= phase + 2'h1;
         if (wr_count) begin
            pre <= 3'h0; // RULE_09
         end else if (run & raw_tick) begin
            pre <= pre_done ? 3'h0 : pre + 3'h1; // RULE_08 RULE_04
         end
      end
   end

   // a pin already high at enable must fall before it counts
   // falling-edge arming for counter mode
   always @(posedge clk) begin
      if (rst | wr_count) begin
         armed <= 1'b0; // RULE_07
      end else if (!on && ext_s) begin
         armed <= 1'b0; // RULE_07
      end else if (on && fall) begin
         armed <= 1'b1; // RULE_07
      end
   end

   // the counter; byte writes take precedence over increments
   always @(posedge clk) begin
      if (rst) begin
         count <= `TMC_COUNT_RESET;
      end else if (wr_low) begin
         count[7:0] <= pwdata[7:0]; // RULE_02
      end else if (wr_high) begin
         count[15:8] <= pwdata[7:0]; // RULE_02
      end else if (inc) begin
         count <= count + 16'h0001; // RULE_01
      end
   end

   // control register
   always @(posedge clk) begin
      if (rst) begin
         ctrl <= `TMC_CTL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= pwdata[`TMC_CTL_W-1:0];
      end
   end

   // pin register; directions reset to input
   always @(posedge clk) begin
      if (rst) begin
         pins <= `TMC_PIN_RESET;
      end else if (wr_pins) begin
         pins <= pwdata[`TMC_PIN_W-1:0];
      end
   end

   // sticky overflow flag: a set in the clearing cycle wins
   always @(posedge clk) begin
      if (rst) begin
         overflow_flag <= 1'b0;
      end else if (roll) begin
         overflow_flag <= 1'b1; // RULE_17
      end else if (wr_stat && !pwdata[`TMC_STA_OVF]) begin
         overflow_flag <= 1'b0; // RULE_17
      end
   end

   // wake request, held until the core leaves sleep
   always @(posedge clk) begin
      if (rst) begin
         wake <= 1'b0;
      end else if (roll & sleep & async) begin
         wake <= 1'b1; // RULE_14
      end else if (!sleep) begin
         wake <= 1'b0;
      end
   end

   // oscillator and pin drivers
   always @(posedge clk) begin
      if (rst) begin
         osc_run  <= 1'b0;
         pin4_out <= 1'b0;
         pin4_oe  <= 1'b0;
         pin5_out <= 1'b0;
         pin5_oe  <= 1'b0;
      end else begin
         osc_run  <= osc_on; // RULE_10 RULE_11
         pin4_out <= pins[`TMC_PIN_OUT4];
         pin5_out <= pins[`TMC_PIN_OUT5];
         pin4_oe  <= ~pins[`TMC_PIN_DIR4] & ~osc_on; // RULE_12
         pin5_oe  <= ~pins[`TMC_PIN_DIR5] & ~osc_on; // RULE_12
      end
   end

   // read view of the pin register
   reg [31:0] pin_view;
   always @* begin
      pin_view = 32'h0000_0000;
      pin_view[`TMC_PIN_DIR4] = pins[`TMC_PIN_DIR4] | osc_on; // RULE_12
      pin_view[`TMC_PIN_DIR5] = pins[`TMC_PIN_DIR5] | osc_on; // RULE_12
      pin_view[`TMC_PIN_OUT4] = pins[`TMC_PIN_OUT4];
      pin_view[`TMC_PIN_OUT5] = pins[`TMC_PIN_OUT5];
      pin_view[`TMC_PIN_IN4]  = p4_s & ~osc_on; // RULE_12
      pin_view[`TMC_PIN_IN5]  = p5_s & ~osc_on; // RULE_12
   end

   // read data for the addressed register, zero elsewhere
   reg [31:0] next_prdata;
   always @* begin
      next_prdata = 32'h0000_0000;
      if (rd_req) begin
         case (paddr)
            `TMC_ADDR_CTRL:   next_prdata = {23'h0, ctrl};
            `TMC_ADDR_LOW:    next_prdata = {24'h0, count[7:0]}; // RULE_01
            `TMC_ADDR_HIGH:   next_prdata = {24'h0, count[15:8]}; // RULE_01
            `TMC_ADDR_STATUS: next_prdata = {30'h0, wake, overflow_flag};
            `TMC_ADDR_PINS:   next_prdata = pin_view;
            default:          next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // apb slave: one wait state, registered answer
   always @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped(paddr);
         prdata  <= next_prdata;
      end
   end

endmodule
`default_nettype wire

// ### sim/tmc_ext_src.sv
`timescale 1ns/100ps
`default_nettype none
module tmc_ext_src (
   input  wire logic clk, // system clock, paces the edges
   output var  logic pin  // external count level
);
   // idle low between bursts, so a burst opens with a rising edge
   initial pin = 1'b0;
   // send n rising edges, ten clocks per half period
   task automatic burst(input int n);
      repeat (n) begin
         repeat (10) @(posedge clk);
         pin <= 1'b1;
         repeat (10) @(posedge clk);
         pin <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ### sim/tmc_timer_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "tmc_regs.vh"
module tmc_timer_properties (
   input wire logic        clk,           // system clock
   input wire logic        rst,           // reset
   input wire logic        psel,          // apb select
   input wire logic        penable,       // apb access
   input wire logic        pwrite,        // apb direction
   input wire logic [7:0]  paddr,         // apb address
   input wire logic [31:0] pwdata,        // apb write data
   input wire logic [31:0] prdata,        // apb read data
   input wire logic        pready,        // apb ready
   input wire logic        pslverr,       // apb error
   input wire logic        pin4_oe,       // pin 4 drive
   input wire logic        pin5_oe,       // pin 5 drive
   input wire logic        osc_allowed,   // clock mode allows osc
   input wire logic        osc_run,       // oscillator on
   input wire logic        overflow_flag, // rollover flag
   input wire logic        sleep,         // core asleep
   input wire logic        wake           // wake request
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // apb phases
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable; endsequence
   // software write of zero to the flag bit
   wire logic clr;
   assign clr = psel && penable && pready && pwrite &&
                paddr == `TMC_ADDR_STATUS && !pwdata[`TMC_STA_OVF];
   a_access_answer: assert property (s_setup ##1 s_access |=> pready)
      else $error("no answer one cycle into the access phase");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held for more than one cycle");
   a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read returned data");
   a_flag_sticky: assert property (overflow_flag && !clr |=> overflow_flag)
      else $error("overflow flag dropped without a clear");
   a_osc_allowed: assert property (!osc_allowed |=> !osc_run)
      else $error("oscillator ran in a clock mode that forbids it");
   a_osc_pins_in: assert property (osc_run |-> !pin4_oe && !pin5_oe)
      else $error("oscillator pin driven while oscillator runs");
   a_wake_sleep: assert property ($rose(wake) |-> $past(sleep))
      else $error("wake raised while awake");
   a_wake_drop: assert property (!sleep |=> !wake)
      else $error("wake held after leaving sleep");
endmodule
bind tmc_timer tmc_timer_properties u_props (.clk(clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pin4_oe(pin4_oe), .pin5_oe(pin5_oe), .osc_allowed(osc_allowed),
   .osc_run(osc_run), .overflow_flag(overflow_flag), .sleep(sleep),
   .wake(wake));
`default_nettype wire

// ### sim/test_gated_16bit_timer_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "tmc_regs.vh"
module test_gated_16bit_timer_counter;
   logic        clk = 1'b0, rst = 1'b1, sleep = 1'b0, osc_allowed = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] c, c2;
   logic        pready, pslverr, err, ext_pin, p4o, p4e, p5o, p5e;
   logic        osc_run, ovf, wake;
   logic        gate = 1'b0, pin_in = 1'b0;
   int          failures = 0, cmp_count = 0, cycles = 0, k;
   // 10 MHz clock
   always #50 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         failures++;
         end_of_test();
      end
   end
   tmc_timer dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_count_pin(ext_pin),
      .gate_pin(gate), .pin4_in(pin_in), .pin5_in(pin_in), .pin4_out(p4o),
      .pin4_oe(p4e), .pin5_out(p5o), .pin5_oe(p5e), .sleep(sleep),
      .osc_allowed(osc_allowed), .osc_run(osc_run),
      .overflow_flag(ovf), .wake(wake));
   tmc_ext_src src (.clk(clk), .pin(ext_pin));
   // one apb transfer, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // compare, allowing one count of slack when tol is nonzero
   task automatic chk(input logic [31:0] got, exp, input int tol);
      cmp_count++;
      if (!(got === exp || (tol > 0 &&
            (got === exp + 32'h1 || got === exp - 32'h1)))) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // count as two bytes
   task automatic getc();
      apb(1'b0, `TMC_ADDR_LOW, 32'h0);
      c[7:0] = rd[7:0];
      apb(1'b0, `TMC_ADDR_HIGH, 32'h0);
      c[15:8] = rd[7:0];
   endtask
   task automatic setc(input logic [15:0] v);
      apb(1'b1, `TMC_ADDR_LOW, {24'h0, v[7:0]});
      apb(1'b1, `TMC_ADDR_HIGH, {24'h0, v[15:8]});
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, `TMC_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0, 0);
      apb(1'b0, `TMC_ADDR_PINS, 32'h0);
      chk(rd, 32'h3, 0);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h0, 0);
      chk({31'h0, err}, 32'h1, 0);
      setc(16'hab12);
      getc();
      chk({16'h0, c}, 32'hab12, 0);
      // on for 204 clocks: four prescales on full clock, then div8 on fosc/4
      for (k = 0; k < 5; k++) begin
         setc(16'h0);
         apb(1'b1, `TMC_ADDR_CTRL, k < 4 ? 32'h101 | (k << 4) : 32'h031);
         repeat (200) @(posedge clk);
         apb(1'b1, `TMC_ADDR_CTRL, 32'h0);
         getc();
         chk({16'h0, c}, 32'd204 >> (k < 4 ? k : 5), 1);
         c2 = c;
         repeat (20) @(posedge clk);
         getc();
         chk({16'h0, c}, {16'h0, c2}, 0);
      end
      setc(16'hfffe);
      apb(1'b1, `TMC_ADDR_CTRL, 32'h101);
      apb(1'b1, `TMC_ADDR_CTRL, 32'h0);
      apb(1'b0, `TMC_ADDR_STATUS, 32'h0);
      chk(rd & 32'h1, 32'h1, 0);
      chk({31'h0, ovf}, 32'h1, 0);
      apb(1'b1, `TMC_ADDR_STATUS, 32'h0);
      apb(1'b0, `TMC_ADDR_STATUS, 32'h0);
      chk(rd & 32'h1, 32'h0, 0);
      chk({31'h0, ovf}, 32'h0, 0);
      // gate active high counts, gate active low holds
      gate <= 1'b1;
      for (k = 0; k < 2; k++) begin
         setc(16'h0);
         apb(1'b1, `TMC_ADDR_CTRL, k ? 32'h141 : 32'h1c1);
         repeat (100) @(posedge clk);
         apb(1'b1, `TMC_ADDR_CTRL, 32'h0);
         getc();
         chk({16'h0, c}, k ? 32'h0 : 32'd104, 0);
      end
      // first rising edge after a count write is not counted
      setc(16'h0);
      apb(1'b1, `TMC_ADDR_CTRL, 32'h003);
      src.burst(5);
      repeat (5) @(posedge clk);
      apb(1'b1, `TMC_ADDR_CTRL, 32'h004);
      getc();
      chk({16'h0, c}, 32'h4, 0);
      apb(1'b1, `TMC_ADDR_CTRL, 32'h007);
      src.burst(3);
      repeat (5) @(posedge clk);
      apb(1'b1, `TMC_ADDR_CTRL, 32'h004);
      getc();
      chk({16'h0, c}, 32'h7, 1);
      // asynchronous counting in sleep wakes on rollover
      setc(16'hffff);
      apb(1'b1, `TMC_ADDR_CTRL, 32'h007);
      sleep <= 1'b1;
      src.burst(3);
      repeat (5) @(posedge clk);
      chk({31'h0, wake}, 32'h1, 0);
      sleep <= 1'b0;
      repeat (2) @(posedge clk);
      chk({31'h0, wake}, 32'h0, 0);
      apb(1'b1, `TMC_ADDR_CTRL, 32'h0);
      // oscillator only in allowed modes, then pins forced to input
      osc_allowed <= 1'b0;
      pin_in <= 1'b1;
      apb(1'b1, `TMC_ADDR_PINS, 32'hc);
      @(posedge clk);
      chk({28'h0, p5o, p4o, p5e, p4e}, 32'hf, 0);
      apb(1'b0, `TMC_ADDR_PINS, 32'h0);
      chk(rd & 32'h33, 32'h30, 0);
      apb(1'b1, `TMC_ADDR_CTRL, 32'h008);
      chk({31'h0, osc_run}, 32'h0, 0);
      osc_allowed <= 1'b1;
      repeat (2) @(posedge clk);
      chk({30'h0, osc_run, p4e | p5e}, 32'h2, 0);
      apb(1'b0, `TMC_ADDR_PINS, 32'h0);
      chk(rd & 32'h33, 32'h3, 0);
      end_of_test();
   end
endmodule
`default_nettype wire
